// ==== uart_mode_pkg.sv ====
package uart_mode_pkg;
   // bus geometry
   localparam int          ADDR_W       = 8;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // register byte addresses
   localparam logic [7:0]  MODE_OFS     = 8'h00;
   localparam logic [7:0]  CARD_OFS     = 8'h04;
   localparam logic [7:0]  RATE_OFS     = 8'h08;
   localparam logic [7:0]  TXD_OFS      = 8'h0C;
   localparam logic [7:0]  STAT_OFS     = 8'h10;
   // mode register fields
   localparam int          EN_BIT       = 15;
   localparam int          RSV_HI_BIT   = 14;
   localparam int          SIDL_BIT     = 13;
   localparam int          IR_BIT       = 12;
   localparam int          REQUEST_PIN_MODE_BIT    = 11;
   localparam int          RSV_LO_BIT   = 10;
   localparam int          UEN_LO       = 8;
   localparam int          WAKE_BIT     = 7;
   localparam int          LPBK_BIT     = 6;
   localparam int          ABD_BIT      = 5;
   localparam int          RXINV_BIT    = 4;
   localparam int          HS_BIT       = 3;
   localparam int          PDS_LO       = 1;
   localparam int          STOP_BIT     = 0;
   localparam logic [15:0] MODE_RST     = 16'h0000;
   localparam logic [15:0] MODE_WMASK   = 16'hBBFF;
   localparam logic [15:0] RATE_RST     = 16'h0000;
   // pin usage codes
   localparam logic [1:0]  PIN_TXRX     = 2'h0;
   localparam logic [1:0]  PIN_RTS      = 2'h1;
   localparam logic [1:0]  PIN_RTSCTS   = 2'h2;
   localparam logic [1:0]  PIN_BCLK     = 2'h3;
   // frame format codes
   localparam logic [1:0]  FMT_8N       = 2'h0;
   localparam logic [1:0]  FMT_8E       = 2'h1;
   localparam logic [1:0]  FMT_8O       = 2'h2;
   localparam logic [1:0]  FMT_9N       = 2'h3;
   localparam logic [3:0]  BITS_8       = 4'h8;
   localparam logic [3:0]  BITS_9       = 4'h9;
   // oversampling and infrared timing, in sub ticks
   localparam logic [4:0]  OVS_STD      = 5'h10;
   localparam logic [4:0]  OVS_HS       = 5'h04;
   localparam logic [4:0]  IR_PULSE     = 5'h03;
   localparam logic [4:0]  IR_HOLD      = 5'h10;
   // auto rate: falling edges of the sync char and divide shifts
   localparam logic [7:0]  SYNC_CHAR    = 8'h55;
   localparam logic [2:0]  ABD_EDGES    = 3'h4;
   localparam int          ABD_SH_STD   = 7;
   localparam int          ABD_SH_HS    = 5;
   // transmitter states
   typedef enum logic [4:0] {
      TX_IDLE  = 5'b00001,
      TX_START = 5'b00010,
      TX_DATA  = 5'b00100,
      TX_PAR   = 5'b01000,
      TX_STOP  = 5'b10000
   } tx_state_e;
endpackage

// ==== mode_if.sv ====
`timescale 1ns/10ps
interface mode_if;
   logic        run;
   logic        high_speed;
   logic        restart;
   logic [15:0] divisor;
   logic        sub_tick;
   logic        bit_tick;
   logic [4:0]  phase;
   logic        bclk;
   logic        ir_active;
   logic        tx_bit;
   logic        rx_pin;
   logic        tx_out;
   logic        rx_bit;
   modport gen (input run, high_speed, restart, divisor,
                output sub_tick, bit_tick, phase, bclk);
   modport codec (input ir_active, tx_bit, rx_pin, sub_tick, phase,
                  output tx_out, rx_bit);
endinterface

// ==== baud_gen.sv ====
`timescale 1ns/10ps
module baud_gen
   import uart_mode_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   mode_if.gen      bus
);
   logic [15:0] cnt_q;
   logic [4:0]  phase_q;
   logic        bclk_q;
   logic [4:0]  ovs;

   // sub ticks per bit follow the speed select
   assign ovs          = bus.high_speed ? OVS_HS : OVS_STD; // RULE11
   assign bus.sub_tick = bus.run && (cnt_q == bus.divisor);
   assign bus.bit_tick = bus.sub_tick && (phase_q >= ovs - 5'h01);
   assign bus.phase    = phase_q;
   assign bus.bclk     = bclk_q;

   // divisor timer, restarted on a software divisor write so no wrap is awaited
   always_ff @(posedge aclk) begin
      if (!aresetn || !bus.run || bus.restart)
         cnt_q <= 16'h0000;
      else if (bus.sub_tick)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_q + 16'h0001;
   end

   // sub tick position within the bit
   always_ff @(posedge aclk) begin
      if (!aresetn || !bus.run)
         phase_q <= 5'h00;
      else if (bus.bit_tick)
         phase_q <= 5'h00;
      else if (bus.sub_tick)
         phase_q <= phase_q + 5'h01;
   end

   // sub tick rate clock, high for the first half of each period
   always_ff @(posedge aclk) begin
      if (!aresetn || !bus.run)
         bclk_q <= 1'b0;
      else
         bclk_q <= (cnt_q <= (bus.divisor >> 1));
   end

   a_bit_after_ovs: assert property (@(posedge aclk) // RULE11
      disable iff (!aresetn)
      (bus.bit_tick && !bus.high_speed) |-> phase_q == OVS_STD - 5'h01)
      else $error("bit tick not at last sub tick");
endmodule

// ==== infrared_codec.sv ====
`timescale 1ns/10ps
module infrared_codec
   import uart_mode_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   mode_if.codec    bus
);
   logic       tx_q;
   logic       rx_q;
   logic [4:0] hold_q;

   assign bus.tx_out = tx_q;
   assign bus.rx_bit = rx_q;

   // encoder: a zero bit is a short pulse, a one bit is dark
   always_ff @(posedge aclk) begin
      if (!aresetn)
         tx_q <= 1'b1;
      else if (bus.ir_active)
         tx_q <= !bus.tx_bit && (bus.phase < IR_PULSE); // RULE1 RULE2
      else
         tx_q <= bus.tx_bit;
   end

   // pulse stretch so a short flash reads as a whole zero bit
   always_ff @(posedge aclk) begin
      if (!aresetn || !bus.ir_active)
         hold_q <= 5'h00;
      else if (bus.rx_pin)
         hold_q <= IR_HOLD;
      else if (bus.sub_tick && hold_q != 5'h00)
         hold_q <= hold_q - 5'h01;
   end

   // decoder output, plain line when infrared is off
   always_ff @(posedge aclk) begin
      if (!aresetn)
         rx_q <= 1'b1;
      else if (bus.ir_active)
         rx_q <= !(bus.rx_pin || hold_q != 5'h00); // RULE2
      else
         rx_q <= bus.rx_pin;
   end

   a_ir_one_dark: assert property (@(posedge aclk) // RULE1
      disable iff (!aresetn)
      (bus.ir_active && bus.tx_bit) |=> !tx_q)
      else $error("infrared one bit produced light");
   a_ir_rx_flash: assert property (@(posedge aclk) // RULE2
      disable iff (!aresetn)
      (bus.ir_active && bus.rx_pin) |=> !rx_q)
      else $error("infrared flash not decoded as zero");
endmodule

// ==== uart_mode_top.sv ====
`timescale 1ns/10ps
// Function
// RULE1 - infrared encoder and decoder run only while mode bit 12 set
// RULE2 - with infrared on, receive pin is detector, transmit pin drives emitter
// RULE3 - infrared coding works only with the 16x standard speed setting
// RULE4 - card control bit chooses byte protocol or block protocol
// RULE5 - enable bit 15 gives pins to the port, else latches own all
// RULE6 - stop-in-idle bit 13 halts the port during device idle
// RULE7 - bit 11 set gives simplex request pin, clear gives flow control
// RULE8 - pin usage field picks tx/rx, plus rts, plus cts, or baud clock
// RULE9 - mode bits 14 and 10 always read as zero
// RULE10 - mode bits reset to zero; wake and auto rate cleared by hardware
// RULE11 - high speed gives 4 sub clocks per bit, else 16
// RULE12 - format field: 8 none, 8 even, 8 odd, 9 none
// RULE13 - stop select set sends two stop bits, clear sends one
// RULE14 - auto rate measures next 0x55 char then clears itself
// RULE15 - writes to unimplemented mode bits are ignored
module uart_mode_top
   import uart_mode_pkg::*;
#(
   parameter int ABD_W = 24
)
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              idle_mode,
   input  wire logic              receive_pin,
   input  wire logic              clear_to_send_pin,
   output logic                   transmit_pin,
   output logic                   transmit_owned,
   output logic                   receive_owned,
   output logic                   request_to_send_pin,
   output logic                   request_owned,
   output logic                   clear_to_send_owned,
   output logic                   card_block_protocol
);
   logic [15:0]      mode_q;
   logic [15:0]      mode_d;
   logic [15:0]      wmask;
   logic             card_q;
   logic [15:0]      rate_q;
   logic             bvalid_q;
   logic [1:0]       bresp_q;
   logic             rvalid_q;
   logic [1:0]       rresp_q;
   logic [31:0]      rdata_q;
   logic             wr_go;
   logic             wr_mode;
   logic             wr_txd;
   logic             wr_rate;
   logic             wr_hit;
   logic             en;
   logic             run;
   logic [1:0]       pin_usage_select;
   logic [1:0]       fmt;
   logic             rx_s1_q;
   logic             rx_s2_q;
   logic             cts_s1_q;
   logic             cts_s2_q;
   logic             rx_line;
   logic             rx_prev_q;
   logic             rx_fall;
   logic             rx_rise;
   logic             wake_seen_q;
   logic             wake_done;
   logic [2:0]       abd_edges_q;
   logic [ABD_W-1:0] abd_cnt_q;
   logic             abd_done;
   logic [ABD_W-1:0] abd_quot;
   tx_state_e        tx_st_q;
   logic [8:0]       tx_sh_q;
   logic [3:0]       tx_cnt_q;
   logic             tx_par_q;
   logic             tx_stop2_q;
   logic             tx_pend_q;
   logic             tx_line_q;
   logic [3:0]       nbits;
   logic             cts_ok;
   logic             tick;

   mode_if mif();

   baud_gen u_gen (
      .aclk    (aclk),
      .aresetn (aresetn),
      .bus     (mif.gen)
   );

   infrared_codec u_ir (
      .aclk    (aclk),
      .aresetn (aresetn),
      .bus     (mif.codec)
   );

   // decoded mode fields
   assign en  = mode_q[EN_BIT];
   assign run = en && !(mode_q[SIDL_BIT] && idle_mode); // RULE6
   assign pin_usage_select = mode_q[UEN_LO +: 2];
   assign fmt = mode_q[PDS_LO +: 2];
   assign tick = mif.bit_tick;

   // baud generator and codec hookup
   assign mif.run        = run;
   assign mif.high_speed = mode_q[HS_BIT];
   assign mif.restart    = wr_rate;
   assign mif.divisor    = rate_q;
   assign mif.ir_active  = en && mode_q[IR_BIT] && !mode_q[HS_BIT]; // RULE1 RULE3
   assign mif.tx_bit     = tx_line_q;
   assign mif.rx_pin     = rx_s2_q;

   // write channel: address and data taken together, one at a time
   assign wr_go   = awvalid && wvalid && !bvalid_q;
   assign awready = wr_go;
   assign wready  = wr_go;
   assign wr_mode = wr_go && awaddr == MODE_OFS;
   assign wr_rate = wr_go && awaddr == RATE_OFS && (wstrb[1:0] != 2'h0);
   assign wr_txd  = wr_go && awaddr == TXD_OFS;
   assign wr_hit  = awaddr == MODE_OFS || awaddr == CARD_OFS ||
                    awaddr == RATE_OFS || awaddr == TXD_OFS ||
                    awaddr == STAT_OFS;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // mode next value: hardware clears first, a software write then wins
   always_comb begin
      wmask  = {{8{wstrb[1]}}, {8{wstrb[0]}}} & MODE_WMASK; // RULE15
      mode_d = mode_q;
      if (abd_done)
         mode_d[ABD_BIT] = 1'b0; // RULE14
      if (wake_done)
         mode_d[WAKE_BIT] = 1'b0; // RULE10
      if (wr_mode)
         mode_d = (mode_d & ~wmask) | (wdata[15:0] & wmask); // RULE9
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         mode_q <= MODE_RST; // RULE10
      else
         mode_q <= mode_d;
   end

   // card protocol select and divisor; software write beats auto rate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         card_q <= 1'b0;
         rate_q <= RATE_RST;
      end else begin
         if (wr_go && awaddr == CARD_OFS && wstrb[0])
            card_q <= wdata[0]; // RULE4
         if (wr_rate)
            rate_q <= wdata[15:0];
         else if (abd_done)
            rate_q <= abd_quot[15:0] - 16'h0001; // RULE14
      end
   end

   assign card_block_protocol = card_q; // RULE4

   // read channel, one cycle answer from flops
   assign arready = !rvalid_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OKAY;
         case (araddr)
            MODE_OFS: rdata_q <= {16'h0000, mode_q};
            CARD_OFS: rdata_q <= {31'h0000_0000, card_q};
            RATE_OFS: rdata_q <= {16'h0000, rate_q};
            TXD_OFS:  rdata_q <= 32'h0000_0000;
            STAT_OFS: rdata_q <= {26'h000_0000, !run, mif.ir_active,
                                  mode_q[ABD_BIT], tx_pend_q,
                                  tx_st_q != TX_IDLE, rx_line};
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // pin synchronisers, first stage read only by the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_s1_q  <= 1'b1;
         rx_s2_q  <= 1'b1;
         cts_s1_q <= 1'b1;
         cts_s2_q <= 1'b1;
      end else begin
         rx_s1_q  <= receive_pin;
         rx_s2_q  <= rx_s1_q;
         cts_s1_q <= clear_to_send_pin;
         cts_s2_q <= cts_s1_q;
      end
   end

   // receive line after loopback and polarity select
   assign rx_line = mode_q[LPBK_BIT] ? tx_line_q
                                     : (mif.rx_bit ^ mode_q[RXINV_BIT]);
   assign rx_fall = rx_prev_q && !rx_line;
   assign rx_rise = !rx_prev_q && rx_line;

   always_ff @(posedge aclk) begin
      if (!aresetn)
         rx_prev_q <= 1'b1;
      else
         rx_prev_q <= rx_line;
   end

   // wake: a falling edge arms, the following rising edge clears the bit
   assign wake_done = mode_q[WAKE_BIT] && wake_seen_q && rx_rise; // RULE10
   always_ff @(posedge aclk) begin
      if (!aresetn || !mode_q[WAKE_BIT] || !en)
         wake_seen_q <= 1'b0;
      else if (rx_fall)
         wake_seen_q <= 1'b1;
   end

   // auto rate: 0x55 gives five falling edges across eight bit times;
   // a non-sync char skews the result, software must send the sync
   assign abd_done = en && mode_q[ABD_BIT] && rx_fall &&
                     abd_edges_q == ABD_EDGES; // RULE14
   assign abd_quot = mode_q[HS_BIT] ? (abd_cnt_q >> ABD_SH_HS)
                                    : (abd_cnt_q >> ABD_SH_STD);

   always_ff @(posedge aclk) begin
      if (!aresetn || !en || !mode_q[ABD_BIT]) begin
         abd_edges_q <= 3'h0;
         abd_cnt_q   <= '0;
      end else if (rx_fall && abd_edges_q != ABD_EDGES) begin
         abd_edges_q <= abd_edges_q + 3'h1;
         // the cycle of the first edge counts, so eight bits give 128
         if (abd_edges_q == 3'h0)
            abd_cnt_q <= {{(ABD_W-1){1'b0}}, 1'b1};
         else
            abd_cnt_q <= abd_cnt_q + 1'b1;
      end else if (abd_edges_q != 3'h0 && !(&abd_cnt_q)) begin
         abd_cnt_q <= abd_cnt_q + 1'b1;
      end
   end

   // transmitter: no buffer, a data write while busy is dropped
   assign nbits  = (fmt == FMT_9N) ? BITS_9 : BITS_8; // RULE12
   assign cts_ok = (pin_usage_select != PIN_RTSCTS) || mode_q[REQUEST_PIN_MODE_BIT] || !cts_s2_q;

   always_ff @(posedge aclk) begin
      if (!aresetn || !en) begin
         tx_st_q    <= TX_IDLE;
         tx_sh_q    <= 9'h000;
         tx_cnt_q   <= 4'h0;
         tx_par_q   <= 1'b0;
         tx_stop2_q <= 1'b0;
         tx_pend_q  <= 1'b0;
         tx_line_q  <= 1'b1;
      end else begin
         if (wr_txd && !tx_pend_q && tx_st_q == TX_IDLE) begin
            tx_pend_q <= 1'b1;
            tx_sh_q   <= (fmt == FMT_9N) ? wdata[8:0] : {1'b0, wdata[7:0]};
            tx_par_q  <= (fmt == FMT_8O) ? ~^wdata[7:0] : ^wdata[7:0]; // RULE12
         end
         case (tx_st_q)
            TX_IDLE: begin
               if (tick && tx_pend_q && cts_ok) begin
                  tx_line_q <= 1'b0;
                  tx_pend_q <= 1'b0;
                  tx_st_q   <= TX_START;
               end
            end
            TX_START: begin
               if (tick) begin
                  tx_line_q <= tx_sh_q[0];
                  tx_sh_q   <= tx_sh_q >> 1;
                  tx_cnt_q  <= 4'h1;
                  tx_st_q   <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tick) begin
                  if (tx_cnt_q == nbits) begin
                     if (fmt == FMT_8E || fmt == FMT_8O) begin
                        tx_line_q <= tx_par_q; // RULE12
                        tx_st_q   <= TX_PAR;
                     end else begin
                        tx_line_q  <= 1'b1;
                        tx_stop2_q <= mode_q[STOP_BIT];
                        tx_st_q    <= TX_STOP;
                     end
                  end else begin
                     tx_line_q <= tx_sh_q[0];
                     tx_sh_q   <= tx_sh_q >> 1;
                     tx_cnt_q  <= tx_cnt_q + 4'h1;
                  end
               end
            end
            TX_PAR: begin
               if (tick) begin
                  tx_line_q  <= 1'b1;
                  tx_stop2_q <= mode_q[STOP_BIT];
                  tx_st_q    <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (tick) begin
                  if (tx_stop2_q)
                     tx_stop2_q <= 1'b0; // RULE13
                  else
                     tx_st_q <= TX_IDLE;
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   // pin ownership; unowned pins fall back to the port latches
   assign transmit_owned      = en; // RULE5
   assign receive_owned       = en;
   assign request_owned       = en && pin_usage_select != PIN_TXRX; // RULE8
   assign clear_to_send_owned = en && pin_usage_select == PIN_RTSCTS;
   assign transmit_pin        = mif.tx_out; // RULE2

   // request pin, active low; shares the pin with the baud clock
   always_comb begin
      if (pin_usage_select == PIN_BCLK)
         request_to_send_pin = mif.bclk; // RULE8
      else if (mode_q[REQUEST_PIN_MODE_BIT])
         request_to_send_pin = !(tx_pend_q || tx_st_q != TX_IDLE); // RULE7
      else
         request_to_send_pin = !run; // RULE7
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_reset_clears_mode: assert property (disable iff (1'b0) // RULE10
      !aresetn |=> mode_q == MODE_RST)
      else $error("mode not zero after reset");
   a_reserved_stay_zero: assert property ( // RULE9
      wr_mode |=> !mode_q[RSV_HI_BIT] && !mode_q[RSV_LO_BIT])
      else $error("reserved mode bit took a write");
   a_high_speed_no_ir: assert property ( // RULE3
      (en && mode_q[HS_BIT]) |=> transmit_pin == $past(tx_line_q))
      else $error("infrared active at high speed");
   a_disable_frees_pins: assert property ( // RULE5
      (wr_mode && wstrb[1] && !wdata[EN_BIT]) |=>
      !transmit_owned && !request_owned && !clear_to_send_owned)
      else $error("pins kept after disable");
   a_idle_halts_ticks: assert property ( // RULE6
      (mode_q[SIDL_BIT] && idle_mode) |-> !mif.sub_tick && !mif.bit_tick)
      else $error("baud ticks during idle halt");
   a_simplex_rts_idle: assert property ( // RULE7
      (en && pin_usage_select == PIN_RTS && mode_q[REQUEST_PIN_MODE_BIT] && !tx_pend_q &&
       tx_st_q == TX_IDLE) |-> request_to_send_pin)
      else $error("simplex request asserted while idle");
   a_basic_pins_only: assert property ( // RULE8
      (en && pin_usage_select == PIN_TXRX) |-> !request_owned && !clear_to_send_owned)
      else $error("extra pins taken in tx rx mode");
   a_parity_bit_sent: assert property ( // RULE12
      (tx_st_q == TX_DATA && tick && tx_cnt_q == nbits &&
       (fmt == FMT_8E || fmt == FMT_8O)) |=>
      tx_st_q == TX_PAR && tx_line_q == $past(tx_par_q))
      else $error("parity bit missing");
   a_two_stop_bits: assert property ( // RULE13
      (tx_st_q == TX_STOP && tick && tx_stop2_q) |=> tx_st_q == TX_STOP)
      else $error("second stop bit skipped");
   a_auto_rate_clears: assert property ( // RULE14
      (abd_done && !wr_mode) |=> !mode_q[ABD_BIT])
      else $error("auto rate bit not cleared");
endmodule

// ==== serial_peer.sv ====
`timescale 1ns/10ps
module serial_peer (
   input  wire logic aclk,
   input  wire logic line,
   output logic      rx_line
);
   int          bit_cycles = 16;
   int          n_bits     = 10;
   logic [15:0] frames[$];
   logic [15:0] w;

   // receive line is never driven here, so it rests at its pulled-up mark
   initial rx_line = 1'b1;

   // mid-bit sampling, lsb first; bit time is set by the bench per mode
   always begin
      @(negedge line);
      repeat (bit_cycles / 2) @(posedge aclk);
      w = '0;
      for (int i = 0; i < n_bits; i++) begin
         repeat (bit_cycles) @(posedge aclk);
         w[i] = line;
      end
      frames.push_back(w);
   end
endmodule

// ==== uart_mode_and_pin_control_test.sv ====
`timescale 1ns/10ps
module uart_mode_and_pin_control_test;
   import uart_mode_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid;
   logic        rvalid, rready, awready, wready, arready, idle_mode;
   logic        receive_pin, transmit_pin, transmit_owned, receive_owned;
   logic        request_to_send_pin, request_owned, clear_to_send_owned;
   logic        card_block_protocol, clear_to_send_pin;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, got;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] v;
   int          n_errors, total_checks, seed, k, fmt;

   uart_mode_top u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .idle_mode, .receive_pin,
      .clear_to_send_pin, .transmit_pin, .transmit_owned,
      .receive_owned, .request_to_send_pin, .request_owned,
      .clear_to_send_owned, .card_block_protocol);
   serial_peer u_peer (.aclk, .line(transmit_pin), .rx_line(receive_pin));

   // bench clock, 25 ns period
   always #12.5 aclk = ~aclk;

   task automatic print_verdict();
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask

   // sampled at the falling edge so the rising edge's updates have landed
   task automatic await(ref logic s);
      for (k = 0; k < 2000; k++) begin
         @(negedge aclk);
         if (s === 1'b1)
            break;
      end
      if (k == 2000) begin
         n_errors++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      await(awready);
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      await(bvalid);
      got = {30'h0, bresp};
      @(posedge aclk);
      bready  <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      await(arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      await(rvalid);
      got = rdata;
      @(posedge aclk);
      rready  <= 1'b0;
   endtask

   // expected line bits after the start bit, stop or idle marks on top
   function automatic logic [15:0] frame_of(input int f, input logic [8:0] d);
      case (f)
         0: return {7'h01, 1'b1, d[7:0]};
         1: return {7'h01, ^d[7:0], d[7:0]};
         2: return {7'h01, ~^d[7:0], d[7:0]};
         default: return {7'h01, d};
      endcase
   endfunction

   // bounded wait for one decoded character, then let the stop bits pass
   task automatic frame(input logic [15:0] x, input bit two);
      for (k = 0; k < 4000 && u_peer.frames.size() == 0; k++)
         @(posedge aclk);
      if (k == 4000) begin
         n_errors++;
         print_verdict();
      end
      chk({16'h0, u_peer.frames.pop_front()}, {16'h0, x});
      // mid second stop bit: busy and receive line idle are the only bits
      if (two) begin
         rd(STAT_OFS);
         chk(got, 32'h3);
      end
      repeat (40) @(posedge aclk);
   endtask

   // reset, then the scenarios in turn
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {idle_mode, clear_to_send_pin, awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      n_errors = 0;
      total_checks = 0;
      seed = 11;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(MODE_OFS);
      chk(got, 32'h0);
      for (int i = 0; i < 8; i++) begin
         v = (16'($random(seed)) & 16'h6C4F) | 16'((i % 4) << 8);
         v = v | 16'((i / 4) << 15);
         wr(MODE_OFS, {16'($random(seed)), v});
         rd(MODE_OFS);
         chk(got, {16'h0, v & MODE_WMASK});
         chk(transmit_owned, v[15]);
         chk(receive_owned, v[15]);
         if (i % 4 == 3) chk(request_to_send_pin, v[15]);
         chk(request_owned, v[15] & (i % 4 != 0));
         chk(clear_to_send_owned, v[15] & (i % 4 == 2));
      end
      for (int i = 1; i >= 0; i--) begin
         wr(CARD_OFS, i);
         chk(card_block_protocol, i);
      end
      wr(8'h20, 32'hFFFF);
      chk(got, {30'h0, RESP_SLVERR});
      for (int h = 0; h < 2; h++)
         for (fmt = 0; fmt < 4; fmt++) begin
            u_peer.bit_cycles = h ? 4 : 16;
            wr(MODE_OFS, 32'h8000 | (h << 3) | (fmt << 1));
            v = 16'($random(seed)) & 16'h01FF;
            wr(TXD_OFS, {16'h0, v});
            frame(frame_of(fmt, v[8:0]), 0);
         end
      u_peer.bit_cycles = 16;
      // hold-off by idle halt, then by clear-to-send high in flow mode
      for (int j = 0; j < 2; j++) begin
         idle_mode <= !j;
         clear_to_send_pin <= j[0];
         wr(MODE_OFS, j ? 32'h8200 : 32'hA000);
         wr(TXD_OFS, 32'h5A);
         repeat (100) @(posedge aclk);
         chk(transmit_pin, 1'b1);
         chk(u_peer.frames.size(), 0);
         idle_mode <= 1'b0;
         clear_to_send_pin <= 1'b0;
         frame(frame_of(0, 9'h05A), 0);
      end
      wr(MODE_OFS, 32'h8001);
      wr(TXD_OFS, 32'hA5);
      frame(frame_of(0, 9'h0A5), 1);
      // loopback feeds the sync char to the rate measurement
      wr(MODE_OFS, 32'h8060);
      wr(TXD_OFS, 32'h55);
      frame(frame_of(0, 9'h055), 0);
      rd(MODE_OFS);
      chk(got, 32'h8040);
      rd(RATE_OFS);
      chk(got, 32'h0);
      wr(MODE_OFS, 32'h8100);
      chk(request_to_send_pin, 1'b0);
      wr(MODE_OFS, 32'h8900);
      chk(request_to_send_pin, 1'b1);
      wr(MODE_OFS, 32'h9000);
      repeat (4) @(posedge aclk);
      chk(transmit_pin, 1'b0);
      wr(MODE_OFS, 32'h9008);
      repeat (4) @(posedge aclk);
      chk(transmit_pin, 1'b1);
      print_verdict();
   end
endmodule
